// *** rtl/playback_command_sequencer.sv ***
// Four-channel playback command sequencer behind a byte-wide command link.
`default_nettype none
`include "playback_command_sequencer_defines.svh"

// Operation
// - Two-byte phrase_cmd_a: gap, then fetch after processing.
// - Channel busy low for processing plus sound.
// - Ready low while preparing, high at start.
// - Item sent within window chains without silence.
// - Start plays preset phrase after final processing.
// - Stop with fade holds busy per rate group.
// - Silence length computed after final processing.
// - Command busy and ready rise after address handling.
// - Silence queued behind phrase keeps ready low.
// - Phrase_cmd_a queued behind silence drops ready again.
// - Busy stays low across whole chained sequence.
// - Loop set honoured only while channel plays.
// - Ready held low during repeat mode.
// - Class D ignores analog volume, uses zero dB.
// - Wide phrase_cmd_a: gaps after two bytes, then fetch.
// - Commands are one, two or three bytes.
// - Fade stop keeps busy low until fade ends.
module playback_command_sequencer #(
  parameter int unsigned WINDOW_CYC  = `WINDOW_MS * 1000 * `CLK_MHZ,
  parameter int unsigned FADE_G0_CYC = `FADE_G0_US * `CLK_MHZ,
  parameter int unsigned FADE_G1_CYC = `FADE_G1_US * `CLK_MHZ,
  parameter int unsigned FADE_G2_CYC = `FADE_G2_US * `CLK_MHZ,
  parameter int unsigned FADE_G3_CYC = `FADE_G3_US * `CLK_MHZ,
  parameter int unsigned FADE_G4_CYC = `FADE_G4_US * `CLK_MHZ
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   link_clk,
  input  wire logic                   link_reset_n,
  input  wire logic                   link_byte_valid,
  input  wire logic [7:0]             link_byte,
  input  wire logic [2:0]             fade_group,
  input  wire logic [3:0]             item_end,
  output logic                        command_busy_n,
  output logic [3:0]                  next_cmd_ready,
  output logic [3:0]                  channel_phrase_cmd_a_busy_n,
  output logic [3:0]                  item_start,
  output logic [3:0]                  item_stop,
  output playback_pkg::item_t [3:0]   item_info,
  output logic [3:0]                  speaker_gain,
  output logic                        class_d_select,
  output logic                        fade_on_halt
);

  // ****************************************************************
  // Command decoding
  // ****************************************************************
  function automatic logic [1:0] cmd_len(input logic [7:0] op);
    if (op == `OP_SEL_W || op == `OP_PHRASE_CMD_A_W) begin
      cmd_len = 2'd3;
    end else if (op[7:4] == `OP_START_HI || op[7:4] == `OP_STOP_HI ||
                 op[7:4] == `OP_LSET_HI || op[7:4] == `OP_LCLR_HI ||
                 op == `OP_PUP0 || op == `OP_PUP1 || op == `OP_WDTCL ||
                 op == `OP_PDWN || op == `OP_ERRCL) begin
      cmd_len = 2'd1;
    end else begin
      cmd_len = 2'd2;
    end
  endfunction

  function automatic logic is_item(input logic [2:0][7:0] b);
    is_item = b[0][7:4] == `OP_PHRASE_CMD_A_HI || b[0] == `OP_PHRASE_CMD_A_W ||
              b[0][7:4] == `OP_START_HI || b[0][7:4] == `OP_SIL_HI;
  endfunction

  function automatic logic [3:0] ch_mask(input logic [2:0][7:0] b);
    if (b[0][7:4] == `OP_PHRASE_CMD_A_HI) begin
      ch_mask = 4'h1 << b[0][1:0];
    end else if (b[0] == `OP_PHRASE_CMD_A_W) begin
      ch_mask = 4'h1 << b[1][5:4];
    end else if (b[0][7:4] == `OP_START_HI || b[0][7:4] == `OP_STOP_HI ||
                 b[0][7:4] == `OP_SIL_HI || b[0][7:4] == `OP_LSET_HI ||
                 b[0][7:4] == `OP_LCLR_HI) begin
      ch_mask = b[0][3:0];
    end else begin
      ch_mask = 4'h0;
    end
  endfunction

  function automatic logic [`TMR_W-1:0] fade_cyc(input logic [2:0] g);
    case (g)
      3'd0:    fade_cyc = `TMR_W'(FADE_G0_CYC);
      3'd1:    fade_cyc = `TMR_W'(FADE_G1_CYC);
      3'd2:    fade_cyc = `TMR_W'(FADE_G2_CYC);
      3'd3:    fade_cyc = `TMR_W'(FADE_G3_CYC);
      default: fade_cyc = `TMR_W'(FADE_G4_CYC);
    endcase
  endfunction

  function automatic logic ch_ready(input playback_pkg::chan_t c);
    ch_ready = c.st == playback_pkg::CH_IDLE ||
               (c.st == playback_pkg::CH_PHRASE_CMD_A && !c.loop && c.win_open);
  endfunction

  // ****************************************************************
  // Link domain
  // ****************************************************************
  // A toggle carries each byte across; the byte register stays put until the
  // next byte, which the host sends only after command busy rises again.
  playback_pkg::link_st_t lk_ff;
  playback_pkg::link_st_t nxt_lk;

  always_comb begin
    nxt_lk = lk_ff;
    if (link_byte_valid) begin
      nxt_lk.data = link_byte;
      nxt_lk.tog  = ~lk_ff.tog;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      lk_ff <= '0;
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // ****************************************************************
  // System domain
  // ****************************************************************
  playback_pkg::sys_st_t st_ff;
  playback_pkg::sys_st_t nxt_st;

  logic            byte_ev;
  logic            last;
  logic [1:0]      len;
  logic [2:0][7:0] bb;
  logic [3:0]      rdy;
  logic [3:0]      mask;
  playback_pkg::item_t it;

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.start_p = 4'h0;
    nxt_st.stop_p  = 4'h0;
    nxt_st.sync    = {st_ff.sync[1:0], lk_ff.tog};
    byte_ev        = st_ff.sync[1] == st_ff.sync[2] && st_ff.sync[2] != st_ff.seen;
    bb             = st_ff.b;
    bb[st_ff.idx]  = lk_ff.data;
    len            = (st_ff.idx == 2'd0) ? cmd_len(lk_ff.data) : st_ff.nbytes;
    last           = len == st_ff.idx + 2'd1;
    mask           = ch_mask(st_ff.b);
    it             = '0;
    for (int c = 0; c < 4; c++) begin
      rdy[c] = ch_ready(st_ff.ch[c]);
    end
    if (byte_ev) begin
      nxt_st.seen = st_ff.sync[2];
    end

    // Per-channel playback progress.
    for (int c = 0; c < 4; c++) begin
      case (st_ff.ch[c].st)
        playback_pkg::CH_PHRASE_CMD_A, playback_pkg::CH_QUEUED: begin
          if (st_ff.ch[c].tmr != '0) begin
            nxt_st.ch[c].tmr = st_ff.ch[c].tmr - `TMR_W'(1);
          end else begin
            nxt_st.ch[c].win_open = 1'b0;
          end
          // A queued item is filled in only when its processing ends, so an earlier end waits.
          if (item_end[c]) begin
            if (st_ff.ch[c].st == playback_pkg::CH_QUEUED && st_ff.acc[c] &&
                st_ff.cst == playback_pkg::CMD_PROC) begin
              nxt_st.ch[c].st = playback_pkg::CH_PREP;
            end else if (st_ff.ch[c].st == playback_pkg::CH_QUEUED) begin
              nxt_st.ch[c].st       = playback_pkg::CH_PHRASE_CMD_A;
              nxt_st.ch[c].cur      = st_ff.ch[c].nxt;
              nxt_st.ch[c].tmr      = `TMR_W'(WINDOW_CYC);
              nxt_st.ch[c].win_open = 1'b1;
              nxt_st.start_p[c]     = 1'b1;
            end else if (st_ff.ch[c].loop) begin
              nxt_st.start_p[c] = 1'b1;
            end else begin
              nxt_st.ch[c].st = playback_pkg::CH_IDLE;
            end
          end
        end
        playback_pkg::CH_FADE: begin
          if (st_ff.ch[c].tmr != '0) begin
            nxt_st.ch[c].tmr = st_ff.ch[c].tmr - `TMR_W'(1);
          end else begin
            nxt_st.ch[c].st = playback_pkg::CH_IDLE;
          end
        end
        default: begin
        end
      endcase
    end

    // Command bytes and processing times.
    case (st_ff.cst)
      playback_pkg::CMD_READY: begin
        if (byte_ev) begin
          nxt_st.b[st_ff.idx] = lk_ff.data;
          nxt_st.nbytes       = len;
          if (last) begin
            nxt_st.cst = playback_pkg::CMD_PROC;
            nxt_st.tmr = `CTMR_W'(`FINAL_BYTE_CYC);
            nxt_st.acc = 4'h0;
            if (is_item(bb)) begin
              nxt_st.acc = ch_mask(bb) & rdy;
              for (int c = 0; c < 4; c++) begin
                if (ch_mask(bb)[c] && rdy[c]) begin
                  nxt_st.ch[c].st = (st_ff.ch[c].st == playback_pkg::CH_IDLE) ?
                                    playback_pkg::CH_PREP :
                                    playback_pkg::CH_QUEUED;
                end
              end
            end
          end else begin
            nxt_st.idx = st_ff.idx + 2'd1;
            nxt_st.cst = playback_pkg::CMD_GAP;
            nxt_st.tmr = `CTMR_W'(`FIRST_BYTE_CYC);
          end
        end
      end
      playback_pkg::CMD_GAP: begin
        if (st_ff.tmr != '0) begin
          nxt_st.tmr = st_ff.tmr - `CTMR_W'(1);
        end else begin
          nxt_st.cst = playback_pkg::CMD_READY;
        end
      end
      playback_pkg::CMD_PROC: begin
        if (st_ff.tmr != '0) begin
          nxt_st.tmr = st_ff.tmr - `CTMR_W'(1);
        end else begin
          nxt_st.cst = playback_pkg::CMD_READY;
          nxt_st.idx = 2'd0;
          for (int c = 0; c < 4; c++) begin
            if (st_ff.b[0][7:4] == `OP_START_HI) begin
              it.phrase = st_ff.ch[c].preset;
            end else if (st_ff.b[0][7:4] == `OP_SIL_HI) begin
              it.is_silence = 1'b1;
              it.sil_len    = st_ff.b[1];
            end else if (st_ff.b[0] == `OP_PHRASE_CMD_A_W) begin
              it.phrase = {st_ff.b[1][3:0], st_ff.b[2]};
            end else begin
              it.phrase = {2'b00, st_ff.b[0][3:2], st_ff.b[1]};
            end
            if (st_ff.acc[c]) begin
              if (nxt_st.ch[c].st == playback_pkg::CH_PREP) begin
                nxt_st.ch[c].st       = playback_pkg::CH_PHRASE_CMD_A;
                nxt_st.ch[c].cur      = it;
                nxt_st.ch[c].loop     = 1'b0;
                nxt_st.ch[c].tmr      = `TMR_W'(WINDOW_CYC);
                nxt_st.ch[c].win_open = 1'b1;
                nxt_st.start_p[c]     = 1'b1;
              end else begin
                nxt_st.ch[c].nxt = it;
              end
            end
            if (st_ff.b[0][7:4] == `OP_SEL_HI && st_ff.b[0][1:0] == 2'(c)) begin
              nxt_st.ch[c].preset = {2'b00, st_ff.b[0][3:2], st_ff.b[1]};
            end
            if (st_ff.b[0] == `OP_SEL_W && st_ff.b[1][5:4] == 2'(c)) begin
              nxt_st.ch[c].preset = {st_ff.b[1][3:0], st_ff.b[2]};
            end
            if (mask[c] && st_ff.b[0][7:4] == `OP_STOP_HI &&
                nxt_st.ch[c].st != playback_pkg::CH_IDLE &&
                nxt_st.ch[c].st != playback_pkg::CH_FADE) begin
              nxt_st.stop_p[c]  = 1'b1;
              nxt_st.ch[c].loop = 1'b0;
              if (st_ff.fade_en) begin
                nxt_st.ch[c].st  = playback_pkg::CH_FADE;
                nxt_st.ch[c].tmr = fade_cyc(fade_group);
              end else begin
                nxt_st.ch[c].st = playback_pkg::CH_IDLE;
              end
            end
            if (mask[c] && st_ff.b[0][7:4] == `OP_LSET_HI &&
                nxt_st.ch[c].st == playback_pkg::CH_PHRASE_CMD_A) begin
              nxt_st.ch[c].loop = 1'b1;
            end
            if (mask[c] && st_ff.b[0][7:4] == `OP_LCLR_HI) begin
              nxt_st.ch[c].loop = 1'b0;
            end
          end
          if (st_ff.b[0][7:2] == `OP_AMODE_HI) begin
            nxt_st.class_d = st_ff.b[0][`AMODE_CLASS_D_SELECT_BIT];
            nxt_st.fade_en = st_ff.b[1][`AMODE_FAD_BIT];
          end
          if (st_ff.b[0] == `OP_ANALOG_VOLUME_CMD) begin
            nxt_st.analog_volume_cmd = st_ff.b[1][5:2];
          end
        end
      end
      default: begin
        nxt_st.cst = playback_pkg::CMD_READY;
      end
    endcase
  end

  // Clock enable freezes the whole system domain, channels included; the link side keeps
  // catching bytes, and a held toggle is seen once the enable returns.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    command_busy_n = st_ff.cst == playback_pkg::CMD_READY;
    for (int c = 0; c < 4; c++) begin
      next_cmd_ready[c]      = rdy[c];
      channel_phrase_cmd_a_busy_n[c] = st_ff.ch[c].st == playback_pkg::CH_IDLE;
      item_info[c]           = st_ff.ch[c].cur;
    end
  end

  assign item_start     = st_ff.start_p;
  assign item_stop      = st_ff.stop_p;
  assign class_d_select = st_ff.class_d;
  assign fade_on_halt   = st_ff.fade_en;
  assign speaker_gain   = st_ff.class_d ? `GAIN_0DB : st_ff.analog_volume_cmd;

endmodule
`default_nettype wire

// *** rtl/playback_command_sequencer_defines.svh ***
// Timing counts, command codes and field positions of the playback command sequencer.
`ifndef PLAYBACK_COMMAND_SEQUENCER_DEFINES_SVH
`define PLAYBACK_COMMAND_SEQUENCER_DEFINES_SVH

// ****************************************************************
// Clock and times
// ****************************************************************
`define CLK_MHZ          100
`define FIRST_BYTE_US    10
`define FINAL_BYTE_US    20
`define WINDOW_MS        10
`define FADE_G0_US       3000
`define FADE_G1_US       5000
`define FADE_G2_US       4000
`define FADE_G3_US       2900
`define FADE_G4_US       2700
`define FIRST_BYTE_CYC   (`FIRST_BYTE_US * `CLK_MHZ)
`define FINAL_BYTE_CYC   (`FINAL_BYTE_US * `CLK_MHZ)
`define TMR_W            20
`define CTMR_W           12

// ****************************************************************
// Command codes and fields
// ****************************************************************
`define OP_SEL_HI        4'h3
`define OP_PHRASE_CMD_A_HI       4'h4
`define OP_START_HI      4'h5
`define OP_STOP_HI       4'h6
`define OP_SIL_HI        4'h7
`define OP_LSET_HI       4'h8
`define OP_LCLR_HI       4'h9
`define OP_SEL_W         8'hc4
`define OP_PHRASE_CMD_A_W        8'hc8
`define OP_ANALOG_VOLUME_CMD          8'h08
`define OP_AMODE_HI      6'h01
`define OP_PUP0          8'h00
`define OP_PUP1          8'h01
`define OP_WDTCL         8'h14
`define OP_PDWN          8'h20
`define OP_ERRCL         8'hff
`define AMODE_CLASS_D_SELECT_BIT   1
`define AMODE_FAD_BIT    7
`define GAIN_0DB         4'h0

`endif

// *** rtl/playback_pkg.sv ***
// Types shared by the playback command sequencer.
`default_nettype none
`include "playback_command_sequencer_defines.svh"
package playback_pkg;

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [1:0] {
    CMD_READY = 2'b00,
    CMD_GAP   = 2'b01,
    CMD_PROC  = 2'b10
  } cmd_state_t;

  typedef enum logic [2:0] {
    CH_IDLE   = 3'b000,
    CH_PREP   = 3'b001,
    CH_PHRASE_CMD_A   = 3'b010,
    CH_QUEUED = 3'b011,
    CH_FADE   = 3'b100
  } ch_state_t;

  // ****************************************************************
  // Records
  // ****************************************************************
  typedef struct packed {
    logic        is_silence;
    logic [11:0] phrase;
    logic [7:0]  sil_len;
  } item_t;

  typedef struct packed {
    ch_state_t          st;
    logic               loop;
    logic               win_open;
    item_t              cur;
    item_t              nxt;
    logic [11:0]        preset;
    logic [`TMR_W-1:0]  tmr;
  } chan_t;

  typedef struct packed {
    logic [7:0] data;
    logic       tog;
  } link_st_t;

  typedef struct packed {
    logic [2:0]          sync;
    logic                seen;
    cmd_state_t          cst;
    logic [1:0]          nbytes;
    logic [1:0]          idx;
    logic [2:0][7:0]     b;
    logic [3:0]          acc;
    logic [`CTMR_W-1:0]  tmr;
    chan_t [3:0]         ch;
    logic                fade_en;
    logic                class_d;
    logic [3:0]          analog_volume_cmd;
    logic [3:0]          start_p;
    logic [3:0]          stop_p;
  } sys_st_t;

endpackage
`default_nettype wire

// *** tb/host_link_model.sv ***
// Host model that sends command bytes over the link.
`default_nettype none
module host_link_model (
  input  wire logic       command_busy_n,
  output logic            link_clk,
  output logic            link_reset_n,
  output logic            link_byte_valid,
  output logic [7:0]      link_byte
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    link_clk = 1'b0;
    link_reset_n = 1'b0;
    link_byte_valid = 1'b0;
    link_byte = 8'h00;
  end

  // The link clock runs only inside a transfer, so the design cannot lean on it.
  task automatic pulse();
    #62.5 link_clk = 1'b1;
    #62.5 link_clk = 1'b0;
  endtask

  task automatic reset_link();
    link_reset_n = 1'b0;
    pulse();
    link_reset_n = 1'b1;
  endtask

  task automatic send(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (command_busy_n !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    ok = (n < 5000);
    link_byte = b;
    link_byte_valid = 1'b1;
    pulse();
    link_byte_valid = 1'b0;
    link_byte = ~b;
    #125;
  endtask
endmodule
`default_nettype wire

// *** tb/playback_command_sequencer_checker.sv ***
// Concurrent checks on the ports of the playback command sequencer.
`default_nettype none
module playback_command_sequencer_checker (
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  input wire logic [3:0]               item_end,
  input wire logic                     command_busy_n,
  input wire logic [3:0]               next_cmd_ready,
  input wire logic [3:0]               channel_phrase_cmd_a_busy_n,
  input wire logic [3:0]               item_start,
  input wire logic [3:0]               item_stop,
  input wire playback_pkg::item_t [3:0] item_info,
  input wire logic [3:0]               speaker_gain,
  input wire logic                     class_d_select,
  input wire logic                     fade_on_halt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Counts how long the byte path stays busy, so gap lengths can be judged.
  logic [11:0] low_cnt_ff;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) low_cnt_ff <= 12'h000;
    else if (command_busy_n) low_cnt_ff <= 12'h000;
    else low_cnt_ff <= low_cnt_ff + 12'h001;
  end

  a_gap_length: assert property ($rose(command_busy_n) |->
    low_cnt_ff inside {[12'h3e7:12'h3ea], [12'h7cf:12'h7d2]}) else $error("bad busy gap");
  a_start_ready: assert property (item_start[0] |-> next_cmd_ready[0])
    else $error("ready not high at start");
  a_start_busy: assert property (item_start[0] |-> !channel_phrase_cmd_a_busy_n[0])
    else $error("busy high at start");
  a_idle_ready: assert property ((channel_phrase_cmd_a_busy_n & ~next_cmd_ready) == 4'h0)
    else $error("idle channel not ready");
  a_end_release: assert property (item_end[0] && next_cmd_ready[0] &&
    !channel_phrase_cmd_a_busy_n[0] |=> channel_phrase_cmd_a_busy_n[0]) else $error("busy kept after end");
  a_chain_hold: assert property (item_end[0] && !next_cmd_ready[0] &&
    !channel_phrase_cmd_a_busy_n[0] |=> item_start[0] && !channel_phrase_cmd_a_busy_n[0])
    else $error("chain broken");
  a_fade_busy: assert property (fade_on_halt && item_stop[1] |->
    !channel_phrase_cmd_a_busy_n[1] ##1 !channel_phrase_cmd_a_busy_n[1]) else $error("fade busy released");
  a_class_d_gain: assert property (class_d_select && $past(class_d_select) |->
    speaker_gain == 4'h0) else $error("gain used with class d");
  a_start_single: assert property (item_start[0] |=> !item_start[0])
    else $error("start pulse too long");

  c_silence: cover property (item_start[0] && item_info[0].is_silence);
  c_stop: cover property (item_stop[1]);
  c_gap: cover property ($rose(command_busy_n));
endmodule

bind playback_command_sequencer playback_command_sequencer_checker i_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .item_end(item_end),
  .command_busy_n(command_busy_n), .next_cmd_ready(next_cmd_ready),
  .channel_phrase_cmd_a_busy_n(channel_phrase_cmd_a_busy_n), .item_start(item_start),
  .item_stop(item_stop), .item_info(item_info), .speaker_gain(speaker_gain),
  .class_d_select(class_d_select), .fade_on_halt(fade_on_halt)
);
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the playback command sequencer.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FG1 = 500;
  logic                     clk_sys, reset_n, clk_en, link_clk, link_reset_n;
  logic                     link_byte_valid, command_busy_n, class_d_select, fade_on_halt;
  logic [7:0]               link_byte;
  logic [2:0]               fade_group;
  logic [3:0]               item_end, next_cmd_ready, channel_phrase_cmd_a_busy_n;
  logic [3:0]               item_start, item_stop, speaker_gain;
  playback_pkg::item_t [3:0] item_info;
  int                       err_count, checks;

  host_link_model i_host (.command_busy_n(command_busy_n), .link_clk(link_clk),
    .link_reset_n(link_reset_n), .link_byte_valid(link_byte_valid), .link_byte(link_byte));

  playback_command_sequencer #(.WINDOW_CYC(20000), .FADE_G0_CYC(300), .FADE_G1_CYC(FG1),
    .FADE_G2_CYC(400), .FADE_G3_CYC(290), .FADE_G4_CYC(270)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .link_clk(link_clk),
    .link_reset_n(link_reset_n), .link_byte_valid(link_byte_valid), .link_byte(link_byte),
    .fade_group(fade_group), .item_end(item_end), .command_busy_n(command_busy_n),
    .next_cmd_ready(next_cmd_ready), .channel_phrase_cmd_a_busy_n(channel_phrase_cmd_a_busy_n),
    .item_start(item_start), .item_stop(item_stop), .item_info(item_info),
    .speaker_gain(speaker_gain), .class_d_select(class_d_select),
    .fade_on_halt(fade_on_halt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] b);
    logic ok;
    i_host.send(b, ok);
    if (!ok) begin
      err_count++;
      $display("Error at %0t: link never free", $time);
      conclude();
    end
  endtask

  // Waits for 0: byte path free, 1: item start, 2: item stop on channel c.
  task automatic wait_for(input int sel, input int c);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit) begin
      hit = (sel == 0) ? command_busy_n === 1'b1 :
            (sel == 1) ? item_start[c] === 1'b1 : item_stop[c] === 1'b1;
      if (!hit) begin
        @(negedge clk_sys);
      end
      n++;
      if (n > 4000 && !hit) begin
        err_count++;
        $display("Error at %0t: wait %0d timed out", $time, sel);
        conclude();
      end
    end
  endtask

  task automatic end_item(input int c);
    item_end[c] = 1'b1;
    @(negedge clk_sys);
    item_end[c] = 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(21'(command_busy_n), 21'h1, "cmd busy");
    chk(21'(next_cmd_ready), 21'hf, "ready");
    chk(21'(channel_phrase_cmd_a_busy_n), 21'hf, "phrase_cmd_a busy");
    $display("test reset done");
  endtask

  task automatic t_chain();
    cmd(8'h40);
    chk(21'(command_busy_n), 21'h0, "gap");
    cmd(8'h05);
    chk(21'({channel_phrase_cmd_a_busy_n[0], next_cmd_ready[0]}), 21'h0, "prep");
    wait_for(1, 0);
    chk(21'({command_busy_n, next_cmd_ready[0]}), 21'h3, "start flags");
    chk(21'(item_info[0].phrase), 21'h005, "phrase");
    cmd(8'h71);
    cmd(8'h08);
    wait_for(0, 0);
    chk(21'(next_cmd_ready[0]), 21'h0, "queued");
    cmd(8'h40);
    cmd(8'h07);
    wait_for(0, 0);
    end_item(0);
    wait_for(1, 0);
    chk(21'({item_info[0].is_silence, item_info[0].sil_len}), 21'h108, "silence");
    chk(21'({channel_phrase_cmd_a_busy_n[0], next_cmd_ready[0]}), 21'h1, "chain");
    end_item(0);
    chk(21'({channel_phrase_cmd_a_busy_n[0], item_start[0]}), 21'h2, "released");
    $display("test chain done");
  endtask

  task automatic t_loop_fade();
    int n;
    cmd(8'h06);
    cmd(8'h80);
    wait_for(0, 0);
    chk(21'({class_d_select, fade_on_halt}), 21'h3, "amp mode");
    cmd(8'h08);
    cmd(8'h3c);
    wait_for(0, 0);
    chk(21'(speaker_gain), 21'h0, "class d gain");
    cmd(8'h04);
    cmd(8'h80);
    wait_for(0, 0);
    chk(21'(speaker_gain), 21'hf, "class ab gain");
    cmd(8'hc8);
    cmd(8'h1f);
    chk(21'(command_busy_n), 21'h0, "wide gap");
    cmd(8'h23);
    wait_for(1, 1);
    chk(21'(item_info[1].phrase), 21'hf23, "wide phrase");
    chk(21'(channel_phrase_cmd_a_busy_n), 21'hd, "only ch1");
    cmd(8'h86);
    wait_for(0, 0);
    chk(21'(next_cmd_ready[2:1]), 21'h2, "loop");
    cmd(8'h62);
    wait_for(2, 1);
    n = 0;
    while (channel_phrase_cmd_a_busy_n[1] === 1'b0 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(21'(n > FG1 - 3 && n < FG1 + 3), 21'h1, "fade length");
    chk(21'(channel_phrase_cmd_a_busy_n[0]), 21'h1, "ch0 done");
    cmd(8'h30);
    cmd(8'h12);
    cmd(8'h51);
    wait_for(1, 0);
    chk(21'(item_info[0].phrase), 21'h012, "preset phrase");
    $display("test loop fade done");
  endtask

  initial begin
    err_count = 0;
    checks = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    fade_group = 3'h1;
    item_end = 4'h0;
    fork
      i_host.reset_link();
      begin
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
      end
    join
    @(negedge clk_sys);
    t_reset();
    t_chain();
    t_loop_fade();
    conclude();
  end
endmodule
`default_nettype wire
